// file: bench/ssc_host.sv
// APB master model standing in for the system processor
`timescale 1ns/10ps
`default_nettype none
module ssc_host #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // One transfer; address and data go first, penable is set one cycle later
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ADDR_W'({idx, 2'b00});
        pwdata <= {16'h0000, wd};
        pstrb <= 4'h3;
        @(posedge pclk);
        penable <= 1'b1;
        // Request held unchanged until pready is seen high at an edge
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines stop showing the last value
        pwdata <= ~pwdata;
        pstrb <= 4'h0;
    endtask : xfer
endmodule : ssc_host
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the software strap loader
`timescale 1ns/10ps
`default_nettype none
`include "ssc_defines.svh"
module tb_top;
    localparam int PULSE = 4; // Internal reset pulse length handed to the design
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] pstrb, advert_abilities;
    logic [1:0] led_scheme_sel;
    logic strap_setup_complete, phy_reset_busy, config_ready, err, bad;
    logic crossover_auto_enable, negotiation_enable, speed_100, full_duplex;
    logic [4:0] s; // {crossover, negotiation, mode[1:0], led}
    int num_errors, checks_done, cyc, n;
    logic [5:0] ridx [5] = '{`SSC_IDX_STRAP, `SSC_IDX_BMC, `SSC_IDX_ADV, `SSC_IDX_XOVER,
        `SSC_IDX_LED};
    logic [15:0] rexp [5] = '{`SSC_RST_STRAP, `SSC_RST_BMC, `SSC_RST_ADV, `SSC_RST_XOVER,
        `SSC_RST_LED};

    ssc_strap_top #(.PULSE_CYC(PULSE), .ADDR_W(8)) ssc_strap_top_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_setup_complete(strap_setup_complete), .phy_reset_busy(phy_reset_busy),
        .config_ready(config_ready), .crossover_auto_enable(crossover_auto_enable),
        .negotiation_enable(negotiation_enable), .speed_100(speed_100),
        .full_duplex(full_duplex), .advert_abilities(advert_abilities),
        .led_scheme_sel(led_scheme_sel));
    ssc_host #(.ADDR_W(8)) ssc_host_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Free-running 50 MHz clock
    always #10 pclk = ~pclk;

    // Hang guard: a few thousand cycles is far beyond the planned run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            finish_test();
        end
    end

    // Repeatable xorshift source
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    // Expected basic mode control word for a strap set
    function automatic logic [15:0] exp_bmc(input logic [4:0] v);
        if (v[3]) return 16'h3100;
        return {2'b00, v[2], 1'b0, 3'b000, v[1], 8'h00};
    endfunction : exp_bmc

    // Expected advertisement word with negotiation enabled
    function automatic logic [15:0] exp_adv(input logic [1:0] m);
        logic [3:0] a;
        a = (m == 2'h0) ? 4'h3 : (m == 2'h1) ? 4'hC : (m == 2'h2) ? 4'h5 : 4'hF;
        return {7'h00, a, 5'h01};
    endfunction : exp_adv

    // Value comparison
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // Register read and compare
    task automatic chk_reg(input logic [5:0] idx, input logic [15:0] exp);
        ssc_host_i.xfer(1'b0, idx, 16'h0000, rd, err);
        chk_val(rd, {16'h0000, exp});
    endtask : chk_reg

    // Program straps, set completion, time the pulse, check the loaded outputs
    task automatic run_cfg(input logic [4:0] v);
        ssc_host_i.xfer(1'b1, `SSC_IDX_STRAP, {1'b0, v, 10'h000}, rd, err);
        // Low bits written as ones must not stick
        ssc_host_i.xfer(1'b1, `SSC_IDX_STRAP, {1'b1, v, 10'h3FF}, rd, err);
        n = 0;
        @(negedge pclk);
        while (phy_reset_busy !== 1'b1 && n < 8) begin
            n++;
            @(negedge pclk);
        end
        n = 0;
        while (phy_reset_busy === 1'b1 && n < 300) begin
            n++;
            @(negedge pclk);
        end
        chk_val(n, PULSE);
        chk_val(config_ready, 1);
        chk_val(strap_setup_complete, 1);
        chk_val({crossover_auto_enable, negotiation_enable, speed_100, full_duplex},
            {v[4], v[3], v[3] | v[2], v[3] | v[1]});
        chk_val(led_scheme_sel, v[0] ? `SSC_LED_SCHEME_1 : `SSC_LED_SCHEME_2);
        chk_reg(`SSC_IDX_STRAP, {1'b1, v, 10'h000});
        chk_reg(`SSC_IDX_BMC, exp_bmc(v));
        chk_reg(`SSC_IDX_XOVER, {v[4], 15'h0000});
        if (v[3]) begin
            chk_reg(`SSC_IDX_ADV, exp_adv(v[2:1]));
            chk_val(advert_abilities, exp_adv(v[2:1]) >> 5);
        end
        // Rewriting straps with completion still set leaves the configuration alone
        ssc_host_i.xfer(1'b1, `SSC_IDX_STRAP, {1'b1, ~v, 10'h000}, rd, err);
        bad = 1'b0;
        repeat (8) begin
            @(negedge pclk);
            bad = bad | (phy_reset_busy !== 1'b0);
        end
        chk_val(bad, 0);
        chk_val({crossover_auto_enable, negotiation_enable, speed_100, full_duplex},
            {v[4], v[3], v[3] | v[2], v[3] | v[1]});
    endtask : run_cfg

    // Counts, verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        seed = 32'h74EF0B61;
        num_errors = 0;
        checks_done = 0;
        cyc = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk_val(config_ready, 0);
        chk_val(led_scheme_sel, `SSC_LED_SCHEME_1);
        chk_val(crossover_auto_enable, 1);
        chk_val(strap_setup_complete, 0);
        for (int i = 0; i < 5; i++) begin
            chk_reg(ridx[i], rexp[i]);
        end
        ssc_host_i.xfer(1'b0, 6'h01, 16'h0000, rd, err);
        chk_val(err, 1);
        chk_val(rd, 0);
        $display("test reset_values done");
        // Every negotiation and mode code, then random strap sets
        for (int i = 0; i < 12; i++) begin
            s = 5'(xorshift());
            if (i < 8) s[3:1] = i[2:0];
            run_cfg(s);
        end
        $display("test strap_decode done");
        // LED strap 0 hands the scheme choice to the LED control bits
        run_cfg(5'b01110);
        for (int i = 1; i < 4; i++) begin
            ssc_host_i.xfer(1'b1, `SSC_IDX_LED, 16'(i << 5), rd, err);
            repeat (2) @(negedge pclk);
            chk_val(led_scheme_sel, `SSC_LED_SCHEME_3);
        end
        ssc_host_i.xfer(1'b1, `SSC_IDX_LED, 16'h0000, rd, err);
        repeat (2) @(negedge pclk);
        chk_val(led_scheme_sel, `SSC_LED_SCHEME_2);
        $display("test led_scheme done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire

// file: verilog/ssc_cfg_if.sv
// Link between the register file and the reset-pulse sequencer
`timescale 1ns/10ps
`default_nettype none
interface ssc_cfg_if;
    import ssc_pkg::*;
    logic done_rise; // Completion bit went from 0 to 1
    logic capture; // Internal reset pulse, straps load while high
    logic ready; // Internal reset sequence finished
    ssc_strap_t strap; // Live strap register contents
    logic [15:0] bmc_load; // Decoded basic mode control default
    logic [15:0] adv_load; // Decoded advertisement default
    modport regs (output done_rise, output strap, input capture, input ready,
        input bmc_load, input adv_load);
    modport seq (input done_rise, input strap, output capture, output ready,
        output bmc_load, output adv_load);
endinterface : ssc_cfg_if
`default_nettype wire

// file: verilog/ssc_defines.svh
// Register indices, field positions, reset values and timing counts of the strap loader
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
// Register indices; byte address is four times the index
`define SSC_IDX_BMC 6'h00
`define SSC_IDX_ADV 6'h04
`define SSC_IDX_STRAP 6'h09
`define SSC_IDX_LED 6'h18
`define SSC_IDX_XOVER 6'h19
// Strap register field positions
`define SSC_STRAP_DONE 15
`define SSC_STRAP_XOVER 14
`define SSC_STRAP_NEGEN 13
`define SSC_STRAP_MODE_HI 12
`define SSC_STRAP_MODE_LO 11
`define SSC_STRAP_LED 10
`define SSC_STRAP_KEEP 16'hFC00
// Basic mode control field positions
`define SSC_BMC_SPEED 13
`define SSC_BMC_NEGEN 12
`define SSC_BMC_DUPLEX 8
// Advertisement field positions (100 full down to 10 half)
`define SSC_ADV_HI 8
`define SSC_ADV_LO 5
`define SSC_ADV_SELECTOR 16'h0001
// Crossover control and LED control field positions
`define SSC_XOVER_AUTO 15
`define SSC_LED_MODE_HI 6
`define SSC_LED_MODE_LO 5
// Reset values
`define SSC_RST_STRAP 16'h7C00
`define SSC_RST_BMC 16'h3100
`define SSC_RST_ADV 16'h01E1
`define SSC_RST_XOVER 16'h8000
`define SSC_RST_LED 16'h0000
// LED scheme encodings on the scheme output
`define SSC_LED_SCHEME_1 2'h1
`define SSC_LED_SCHEME_2 2'h2
`define SSC_LED_SCHEME_3 2'h3
// Length of the internal reset pulse in pclk cycles
`define SSC_PULSE_CYC 4
`endif

// file: verilog/ssc_pkg.sv
// Types shared by the strap loader modules
package ssc_pkg;
    // Loader sequence, Gray coded along wait -> pulse -> run
    typedef enum logic [1:0] {
        SSC_WAIT = 2'h0,
        SSC_PULSE = 2'h1,
        SSC_RUN = 2'h3
    } ssc_state_t;
    // Strap values as captured: crossover, negotiation, mode, LED scheme
    typedef struct packed {
        logic xover;
        logic negen;
        logic [1:0] mode;
        logic led;
    } ssc_strap_t;
endpackage : ssc_pkg

// file: verilog/ssc_seq.sv
// Internal reset pulse sequencer and strap decoder
`timescale 1ns/10ps
`default_nettype none
`include "ssc_defines.svh"
module ssc_seq import ssc_pkg::*; #(
    parameter int PULSE_CYC = `SSC_PULSE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    ssc_cfg_if.seq cfg
);
    // A zero-length pulse would never load the straps
    if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk
        $error("ssc_seq: PULSE_CYC out of range");
    end
    ssc_state_t state_ff; // Sequence state
    ssc_state_t nxt_state; // Next state
    logic [7:0] cnt_ff; // Cycles left in the pulse
    logic [7:0] nxt_cnt; // Next count
    logic ready_ff; // Sequence complete
    logic nxt_ready; // Next ready
    // Forced speed/duplex or advertised abilities from the straps
    function automatic logic [15:0] bmc_of(input ssc_strap_t s);
        logic [15:0] v;
        v = 16'h0000;
        v[`SSC_BMC_NEGEN] = s.negen;
        v[`SSC_BMC_SPEED] = s.negen | s.mode[1];
        v[`SSC_BMC_DUPLEX] = s.negen | s.mode[0];
        return v;
    endfunction : bmc_of
    function automatic logic [15:0] adv_of(input ssc_strap_t s);
        logic [15:0] v;
        v = `SSC_ADV_SELECTOR;
        case (s.mode)
            2'h0: v[`SSC_ADV_HI:`SSC_ADV_LO] = 4'h3; // 10 half and full
            2'h1: v[`SSC_ADV_HI:`SSC_ADV_LO] = 4'hC; // 100 half and full
            2'h2: v[`SSC_ADV_HI:`SSC_ADV_LO] = 4'h5; // 10 half plus 100 half
            default: v[`SSC_ADV_HI:`SSC_ADV_LO] = 4'hF; // All abilities
        endcase
        return v;
    endfunction : adv_of
    assign cfg.bmc_load = bmc_of(cfg.strap);
    assign cfg.adv_load = adv_of(cfg.strap);
    assign cfg.capture = (state_ff == SSC_PULSE);
    assign cfg.ready = ready_ff;
    // Next-state logic; a fresh completion write reruns the pulse
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ready = ready_ff;
        case (state_ff)
            SSC_WAIT, SSC_RUN: begin
                if (cfg.done_rise) begin
                    nxt_state = SSC_PULSE;
                    nxt_cnt = 8'(PULSE_CYC - 1);
                    nxt_ready = 1'b0;
                end
            end
            SSC_PULSE: begin
                if (cnt_ff == 8'h00) begin
                    nxt_state = SSC_RUN;
                    nxt_ready = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            default: nxt_state = SSC_WAIT;
        endcase
    end
    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SSC_WAIT;
            cnt_ff <= 8'h00;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ready_ff <= nxt_ready;
        end
    end
endmodule : ssc_seq
`default_nettype wire

// file: verilog/ssc_strap_top.sv
// Software strap register, APB slave and captured configuration registers
//
// Summary of operation
// - Strap register replaces pin straps at reset
// - Completion set fires pulse that captures straps
// - Completion resets 0; sequence finishes after 1
// - Crossover strap defaults 1, 1 enables auto
// - Crossover strap loads crossover control bit 15
// - Negotiation strap defaults 1; 0 forces mode
// - Forced mode codes select speed and duplex
// - Negotiation codes 00 through 11 advertise sets
// - Decoded straps load mode control and advertisement
// - LED strap 1 scheme1; 0 scheme from LED bits
// - LED strap latched at capture sets scheme
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ssc_defines.svh"
module ssc_strap_top import ssc_pkg::*; #(
    parameter int PULSE_CYC = `SSC_PULSE_CYC,
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic strap_setup_complete,
    output logic phy_reset_busy,
    output logic config_ready,
    output logic crossover_auto_enable,
    output logic negotiation_enable,
    output logic speed_100,
    output logic full_duplex,
    output logic [3:0] advert_abilities,
    output logic [1:0] led_scheme_sel
);
    // The hit decode reads paddr bits 7:2, so 8 bits at least
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
        $error("ssc_strap_top: ADDR_W out of range");
    end

    ssc_cfg_if cfg (); // Link to the pulse sequencer

    // Stored registers
    logic [15:0] strap_ff; // Strap register, bits 15:10 held
    logic [15:0] bmc_ff; // Basic mode control
    logic [15:0] adv_ff; // Advertisement
    logic [15:0] xover_ff; // Crossover control
    logic [15:0] led_ff; // LED control
    logic led_latched_ff; // LED strap captured at the pulse
    logic [31:0] prdata_ff; // Read data, loaded in the setup phase
    logic [1:0] led_sel_ff; // Active LED scheme
    logic [15:0] nxt_strap; // Next strap register
    logic [15:0] nxt_bmc; // Next basic mode control
    logic [15:0] nxt_adv; // Next advertisement
    logic [15:0] nxt_xover; // Next crossover control
    logic [15:0] nxt_led; // Next LED control
    logic nxt_led_latched; // Next latched LED strap
    logic [1:0] nxt_led_sel; // Next LED scheme

    // Decode helper used for every register hit
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
        return (a[7:2] == idx) && (a[1:0] == 2'h0);
    endfunction : hit

    // Bus decode
    wire logic setup_ph = psel & ~penable; // First cycle of a transfer
    wire logic access_ph = psel & penable; // Second cycle, always ready
    wire logic hit_bmc = hit(paddr, `SSC_IDX_BMC);
    wire logic hit_adv = hit(paddr, `SSC_IDX_ADV);
    wire logic hit_strap = hit(paddr, `SSC_IDX_STRAP);
    wire logic hit_led = hit(paddr, `SSC_IDX_LED);
    wire logic hit_xover = hit(paddr, `SSC_IDX_XOVER);
    wire logic hit_any = hit_bmc | hit_adv | hit_strap | hit_led | hit_xover;
    wire logic high_bits_ok = ((paddr >> 8) == '0); // Every bit above the decode must be 0
    wire logic mapped = hit_any & high_bits_ok;
    // Registers are 16 bits wide, so only the two low byte lanes matter
    wire logic wr_en = access_ph & pwrite & mapped & (pstrb[1:0] != 2'h0);
    wire logic [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire logic [15:0] wdata = pwdata[15:0];

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata = prdata_ff;

    // Masked update of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
        input logic [15:0] m);
        return (old & ~m) | (nw & m);
    endfunction : merge

    // Completion going 0 -> 1 starts the internal reset pulse
    wire logic done_wr = wr_en & hit_strap & pstrb[1];
    wire logic done_new = wdata[`SSC_STRAP_DONE];
    assign cfg.done_rise = done_wr & done_new & ~strap_ff[`SSC_STRAP_DONE];

    // Live strap values handed to the decoder
    assign cfg.strap.xover = strap_ff[`SSC_STRAP_XOVER];
    assign cfg.strap.negen = strap_ff[`SSC_STRAP_NEGEN];
    assign cfg.strap.mode = strap_ff[`SSC_STRAP_MODE_HI:`SSC_STRAP_MODE_LO];
    assign cfg.strap.led = strap_ff[`SSC_STRAP_LED];

    // Strap register: bits 9:0 are not held here and read zero
    always_comb begin
        nxt_strap = strap_ff;
        if (wr_en && hit_strap) begin
            nxt_strap = merge(strap_ff, wdata, wmask) & `SSC_STRAP_KEEP;
        end
    end

    // Configuration registers: the pulse loads the decoded straps and wins
    // over a software write in the same cycle
    always_comb begin
        nxt_bmc = bmc_ff;
        nxt_adv = adv_ff;
        nxt_xover = xover_ff;
        nxt_led = led_ff;
        nxt_led_latched = led_latched_ff;
        if (wr_en && hit_bmc) begin
            nxt_bmc = merge(bmc_ff, wdata, wmask);
        end
        if (wr_en && hit_adv) begin
            nxt_adv = merge(adv_ff, wdata, wmask);
        end
        if (wr_en && hit_xover) begin
            nxt_xover = merge(xover_ff, wdata, wmask);
        end
        if (wr_en && hit_led) begin
            nxt_led = merge(led_ff, wdata, wmask);
        end
        if (cfg.capture) begin
            nxt_bmc = cfg.bmc_load;
            nxt_adv = cfg.adv_load;
            nxt_xover[`SSC_XOVER_AUTO] = cfg.strap.xover;
            nxt_led_latched = cfg.strap.led;
        end
    end

    // LED scheme: latched strap 1 gives scheme 1, else LED control picks 2 or 3
    wire logic led_pick3 = nxt_led[`SSC_LED_MODE_LO] | nxt_led[`SSC_LED_MODE_HI];
    always_comb begin
        if (nxt_led_latched) begin
            nxt_led_sel = `SSC_LED_SCHEME_1;
        end else if (led_pick3) begin
            nxt_led_sel = `SSC_LED_SCHEME_3;
        end else begin
            nxt_led_sel = `SSC_LED_SCHEME_2;
        end
    end

    // Read mux, evaluated in the setup phase so data is ready at access
    wire logic [15:0] rd_word =
        hit_bmc ? bmc_ff :
        hit_adv ? adv_ff :
        hit_strap ? strap_ff :
        hit_led ? led_ff :
        hit_xover ? xover_ff : 16'h0000;

    // Strap register flops; completion resets to 0 and the straps to 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_ff <= `SSC_RST_STRAP;
        end else begin
            strap_ff <= nxt_strap;
        end
    end

    // Configuration flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bmc_ff <= `SSC_RST_BMC;
            adv_ff <= `SSC_RST_ADV;
            xover_ff <= `SSC_RST_XOVER;
            led_ff <= `SSC_RST_LED;
            led_latched_ff <= 1'b1;
            led_sel_ff <= `SSC_LED_SCHEME_1;
        end else begin
            bmc_ff <= nxt_bmc;
            adv_ff <= nxt_adv;
            xover_ff <= nxt_xover;
            led_ff <= nxt_led;
            led_latched_ff <= nxt_led_latched;
            led_sel_ff <= nxt_led_sel;
        end
    end

    // Read data register; a read that matches no index in paddr bits 7:0 returns zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata_ff <= {16'h0000, rd_word};
        end
    end

    // Pulse sequencer
    ssc_seq #(
        .PULSE_CYC(PULSE_CYC)
    ) u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg.seq)
    );

    // Outputs, all from flops except the sequencer status decodes
    assign strap_setup_complete = strap_ff[`SSC_STRAP_DONE];
    assign phy_reset_busy = cfg.capture;
    assign config_ready = cfg.ready;
    assign crossover_auto_enable = xover_ff[`SSC_XOVER_AUTO];
    assign negotiation_enable = bmc_ff[`SSC_BMC_NEGEN];
    assign speed_100 = bmc_ff[`SSC_BMC_SPEED];
    assign full_duplex = bmc_ff[`SSC_BMC_DUPLEX];
    assign advert_abilities = adv_ff[`SSC_ADV_HI:`SSC_ADV_LO];
    assign led_scheme_sel = led_sel_ff;

    // Checks on the captured configuration
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_done_fires;
        cfg.done_rise |=> cfg.capture ##0 !config_ready;
    endproperty
    a_done_fires: assert property (p_done_fires) else $error("No pulse after completion");

    property p_pulse_len;
        $rose(cfg.capture) |-> cfg.capture[*4] ##1 (!cfg.capture && config_ready);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("Pulse length wrong");

    property p_ready_needs_done;
        $rose(config_ready) |-> strap_ff[`SSC_STRAP_DONE] || $past(cfg.capture);
    endproperty
    a_ready_needs_done: assert property (p_ready_needs_done) else $error("Ready early");

    property p_xover_load;
        cfg.capture |=> crossover_auto_enable == $past(strap_ff[`SSC_STRAP_XOVER]);
    endproperty
    a_xover_load: assert property (p_xover_load) else $error("Crossover not loaded");

    property p_negen_load;
        cfg.capture |=> negotiation_enable == $past(strap_ff[`SSC_STRAP_NEGEN]);
    endproperty
    a_negen_load: assert property (p_negen_load) else $error("Negotiation not loaded");

    property p_forced;
        cfg.capture && !strap_ff[`SSC_STRAP_NEGEN] |=>
            speed_100 == $past(strap_ff[`SSC_STRAP_MODE_HI]) &&
            full_duplex == $past(strap_ff[`SSC_STRAP_MODE_LO]);
    endproperty
    a_forced: assert property (p_forced) else $error("Forced mode wrong");

    property p_advert;
        cfg.capture && strap_ff[`SSC_STRAP_NEGEN] &&
            strap_ff[`SSC_STRAP_MODE_HI:`SSC_STRAP_MODE_LO] == 2'h2 |=>
            advert_abilities == 4'h5;
    endproperty
    a_advert: assert property (p_advert) else $error("Advertisement wrong");

    property p_led_latch;
        cfg.capture |=> led_latched_ff == $past(strap_ff[`SSC_STRAP_LED]);
    endproperty
    a_led_latch: assert property (p_led_latch) else $error("LED strap not latched");

    property p_hold;
        !cfg.capture |=> $stable(led_latched_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("Latched LED strap moved");

    property p_scheme1;
        led_latched_ff |-> led_scheme_sel == `SSC_LED_SCHEME_1;
    endproperty
    a_scheme1: assert property (p_scheme1) else $error("LED scheme not 1");

    // Sequencer status: the pulse only follows a completion write, and
    // the ready flag stands until the next one
    property p_no_rerun;
        !cfg.capture && !cfg.done_rise |=> !cfg.capture;
    endproperty
    a_no_rerun: assert property (p_no_rerun) else $error("Pulse without completion");

    property p_busy_not_ready;
        cfg.capture |-> !config_ready;
    endproperty
    a_busy_not_ready: assert property (p_busy_not_ready) else $error("Ready in pulse");

    property p_ready_hold;
        config_ready && !cfg.done_rise |=> config_ready;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("Ready dropped");

    // Advertised sets for negotiation codes 00 and 01
    property p_advert_10;
        cfg.capture && strap_ff[`SSC_STRAP_NEGEN] &&
            strap_ff[`SSC_STRAP_MODE_HI:`SSC_STRAP_MODE_LO] == 2'h0 |=>
            advert_abilities == 4'h3;
    endproperty
    a_advert_10: assert property (p_advert_10) else $error("10 advertisement wrong");

    property p_advert_100;
        cfg.capture && strap_ff[`SSC_STRAP_NEGEN] &&
            strap_ff[`SSC_STRAP_MODE_HI:`SSC_STRAP_MODE_LO] == 2'h1 |=>
            advert_abilities == 4'hC;
    endproperty
    a_advert_100: assert property (p_advert_100) else $error("100 advertisement wrong");

    // Only the pulse or a direct write may move a loaded register
    property p_xover_hold;
        !cfg.capture && !(wr_en && hit_xover) |=> $stable(xover_ff);
    endproperty
    a_xover_hold: assert property (p_xover_hold) else $error("Crossover moved");

    property p_bmc_hold;
        !cfg.capture && !(wr_en && hit_bmc) |=> $stable(bmc_ff);
    endproperty
    a_bmc_hold: assert property (p_bmc_hold) else $error("Mode control moved");

    property p_adv_hold;
        !cfg.capture && !(wr_en && hit_adv) |=> $stable(adv_ff);
    endproperty
    a_adv_hold: assert property (p_adv_hold) else $error("Advertisement moved");

    // Bits below the LED strap are not held and must read zero
    property p_strap_low;
        strap_ff[`SSC_STRAP_LED-1:0] == '0;
    endproperty
    a_strap_low: assert property (p_strap_low) else $error("Unheld strap bits set");

    // Latched LED strap 0 leaves the choice to the LED control bits
    property p_scheme23;
        !led_latched_ff |-> led_scheme_sel ==
            ((led_ff[`SSC_LED_MODE_LO] | led_ff[`SSC_LED_MODE_HI]) ?
            `SSC_LED_SCHEME_3 : `SSC_LED_SCHEME_2);
    endproperty
    a_scheme23: assert property (p_scheme23) else $error("LED scheme not 2 or 3");
endmodule : ssc_strap_top
`default_nettype wire
